//--- core_consts.svh
// Field positions, timing counts, debug offsets and opcode patterns of the execute core
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH

// ----------------------------------------------------------------
// Sizes and flag register layout
// ----------------------------------------------------------------
`define PC_W          9
`define STACK_DEPTH   3
`define FLAG_C        0
`define FLAG_Z        1
`define FLAG_N        2
`define FLAG_V        3
`define FLAG_S        4
`define FLAG_H        5
`define FLAG_T        6
`define FLAG_I        7
`define FLAG_RESET    8'h00
`define Z_PTR_LO      5'h1E

// ----------------------------------------------------------------
// Cycle counts per instruction class
// ----------------------------------------------------------------
`define CYC_JUMP      2
`define CYC_CALL      3
`define CYC_RETURN    4
`define CYC_MEM       2
`define CYC_BRANCH    2

// ----------------------------------------------------------------
// Debug port map
// ----------------------------------------------------------------
`define DBG_CTRL      6'h20
`define DBG_FLAGS     6'h21
`define DBG_PC_LO     6'h22
`define DBG_PC_HI     6'h23
`define CTRL_RUN      0
`define CTRL_RESET    8'h00

// ----------------------------------------------------------------
// Opcode patterns (casez, ? is a field bit)
// ----------------------------------------------------------------
`define OPC_ADD       16'b0000_11??_????_????
`define OPC_ADD_C     16'b0001_11??_????_????
`define OPC_SUB       16'b0001_10??_????_????
`define OPC_SUB_B     16'b0000_10??_????_????
`define OPC_SUB_I     16'b0101_????_????_????
`define OPC_SUB_IB    16'b0100_????_????_????
`define OPC_AND       16'b0010_00??_????_????
`define OPC_AND_I     16'b0111_????_????_????
`define OPC_XOR       16'b0010_01??_????_????
`define OPC_OR        16'b0010_10??_????_????
`define OPC_OR_I      16'b0110_????_????_????
`define OPC_MOVE      16'b0010_11??_????_????
`define OPC_CMP       16'b0001_01??_????_????
`define OPC_CMP_B     16'b0000_01??_????_????
`define OPC_CMP_I     16'b0011_????_????_????
`define OPC_CMP_SKIP  16'b0001_00??_????_????
`define OPC_SKRB_CLR  16'b1111_110?_????_0???
`define OPC_SKRB_SET  16'b1111_111?_????_0???
`define OPC_SKIO_CLR  16'b1001_1001_????_????
`define OPC_SKIO_SET  16'b1001_1011_????_????
`define OPC_BRF_SET   16'b1111_00??_????_????
`define OPC_BRF_CLR   16'b1111_01??_????_????
`define OPC_JUMP      16'b1100_????_????_????
`define OPC_CALL      16'b1101_????_????_????
`define OPC_POP_PC    16'b1001_0101_0000_1000
`define OPC_INT_EXIT  16'b1001_0101_0001_1000
`define OPC_LOAD_Z    16'b1000_000?_????_0000
`define OPC_STORE_Z   16'b1000_001?_????_0000
`define OPC_LOAD_K    16'b1110_????_????_????
`define OPC_IO_RD     16'b1011_0???_????_????
`define OPC_IO_WR     16'b1011_1???_????_????

`endif

//--- core_pkg.sv
// Types shared by the execute core and its surroundings
package core_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_SUB_IMM, OP_SUB_IMM_BORROW,
    OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_CMP, OP_CMP_BORROW, OP_CMP_IMM,
    OP_CMP_SKIP, OP_SKIP_RBIT_CLR, OP_SKIP_RBIT_SET, OP_SKIP_IOBIT_CLR, OP_SKIP_IOBIT_SET,
    OP_BR_FLAG_SET, OP_BR_FLAG_CLR, OP_REL_JUMP, OP_REL_CALL, OP_POP_PC, OP_INT_EXIT,
    OP_LOAD_Z, OP_STORE_Z, OP_MOVE, OP_LOAD_CONST, OP_IO_READ, OP_IO_WRITE
  } op_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } io_req_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dbg_req_t;

endpackage

//--- tiny_core_instruction_execute.sv
// Execute core: decode, ALU, flags, branch, skip, return stack and debug port
// Behaviour
// - add writes Rd plus source, plus carry for carry form; six flags; one cycle
// - register subtract writes Rd minus source, minus carry for borrow form; six flags
// - immediate subtract writes Rd minus constant, minus carry for borrow form; six flags
// - AND with register or constant updates Z, N, V, S only; C and H kept
// - OR with register or constant updates Z, N, V, S only; one cycle
// - mask-set instruction is the immediate OR with identical flags
// - mask-clear instruction is AND with inverted mask; Z, N, V, S only
// - zero-sign probe ANDs a register with itself, value unchanged, flags Z N V S
// - compares compute the difference, write nothing, update six flags, one cycle
// - compare-skip skips next word when equal; one cycle or two; no flags
// - register-bit skips test one bit, skip on clear or set; one or two cycles
// - I/O-bit skips test one I/O bit, skip on clear or set; one or two
// - flag branch loads PC plus offset plus one when bit matches; two cycles, else one
// - signed branches use N xor V: not-less when 0, less when 1
// - unsigned branches use carry: not-lower when 0, lower when 1
// - overflow branches follow V with the usual target and timing
// - half-carry branches follow H with the usual target and timing
// - transfer-bit branches follow T with the usual target and timing
// - interrupt-state branches follow I and alter no flag
// - both returns reload PC from the stack in four cycles; arithmetic flags kept
`timescale 1ns/100ps
`include "core_consts.svh"
module tiny_core_instruction_execute (
  input  wire logic                clk,
  input  wire logic                reset_n,
  output logic [`PC_W-1:0]         pm_addr,
  input  wire logic [15:0]         pm_data,
  output core_pkg::io_req_t        io_req,
  input  wire logic [7:0]          io_rdata,
  input  wire core_pkg::dbg_req_t  dbg_req,
  output logic [7:0]               dbg_rdata,
  output logic                     issue,
  output logic [7:0]               flags
);
  import core_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       rf_q [32];
  logic [`PC_W-1:0] stk_q [`STACK_DEPTH];
  logic [7:0]       flag_q, flag_d;
  logic [`PC_W-1:0] pc_q, pc_d;
  logic [1:0]       wait_q, wait_d;
  logic             skip_q, skip_d;
  logic [7:0]       ctrl_q;
  logic [7:0]       dbg_rdata_q;
  logic             push, pop;
  op_t              op;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  wire [15:0]       ins      = pm_data;
  wire [4:0]        d_full   = ins[8:4];
  wire [4:0]        d_hi     = {1'b1, ins[7:4]};
  wire [4:0]        r_sel    = {ins[9], ins[3:0]};
  wire [7:0]        k_imm    = {ins[11:8], ins[3:0]};
  wire [2:0]        bit_sel  = ins[2:0];
  wire [6:0]        br_off   = ins[9:3];
  wire [5:0]        io_addr  = {ins[10:9], ins[3:0]};
  wire [4:0]        iob_addr = ins[7:3];
  wire              run      = ctrl_q[`CTRL_RUN];
  wire              exec     = run & (wait_q == 2'h0) & ~skip_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Unknown codes fall to a one-cycle no-op so the core never locks up
  always_comb begin
    op = OP_NOP;
    casez (ins)
      `OPC_ADD:      op = OP_ADD;
      `OPC_ADD_C:    op = OP_ADD_CARRY;
      `OPC_SUB:      op = OP_SUB;
      `OPC_SUB_B:    op = OP_SUB_BORROW;
      `OPC_SUB_I:    op = OP_SUB_IMM;
      `OPC_SUB_IB:   op = OP_SUB_IMM_BORROW;
      `OPC_AND:      op = OP_AND;
      `OPC_AND_I:    op = OP_AND_IMM;
      `OPC_XOR:      op = OP_XOR;
      `OPC_OR:       op = OP_OR;
      `OPC_OR_I:     op = OP_OR_IMM;
      `OPC_MOVE:     op = OP_MOVE;
      `OPC_CMP:      op = OP_CMP;
      `OPC_CMP_B:    op = OP_CMP_BORROW;
      `OPC_CMP_I:    op = OP_CMP_IMM;
      `OPC_CMP_SKIP: op = OP_CMP_SKIP;
      `OPC_SKRB_CLR: op = OP_SKIP_RBIT_CLR;
      `OPC_SKRB_SET: op = OP_SKIP_RBIT_SET;
      `OPC_SKIO_CLR: op = OP_SKIP_IOBIT_CLR;
      `OPC_SKIO_SET: op = OP_SKIP_IOBIT_SET;
      `OPC_BRF_SET:  op = OP_BR_FLAG_SET;
      `OPC_BRF_CLR:  op = OP_BR_FLAG_CLR;
      `OPC_JUMP:     op = OP_REL_JUMP;
      `OPC_CALL:     op = OP_REL_CALL;
      `OPC_POP_PC:   op = OP_POP_PC;
      `OPC_INT_EXIT: op = OP_INT_EXIT;
      `OPC_LOAD_Z:   op = OP_LOAD_Z;
      `OPC_STORE_Z:  op = OP_STORE_Z;
      `OPC_LOAD_K:   op = OP_LOAD_CONST;
      `OPC_IO_RD:    op = OP_IO_READ;
      `OPC_IO_WR:    op = OP_IO_WRITE;
      default:       op = OP_NOP;
    endcase
  end

  wire imm_op = op inside {OP_SUB_IMM, OP_SUB_IMM_BORROW, OP_AND_IMM, OP_OR_IMM,
                           OP_CMP_IMM, OP_LOAD_CONST};
  wire is_add = op inside {OP_ADD, OP_ADD_CARRY};
  wire is_sub = op inside {OP_SUB, OP_SUB_BORROW, OP_SUB_IMM, OP_SUB_IMM_BORROW,
                           OP_CMP, OP_CMP_BORROW, OP_CMP_IMM};
  wire is_cmp = op inside {OP_CMP, OP_CMP_BORROW, OP_CMP_IMM};
  wire is_and = op inside {OP_AND, OP_AND_IMM};
  wire is_or  = op inside {OP_OR, OP_OR_IMM};
  wire is_log = is_and | is_or | (op == OP_XOR);
  wire is_skp = op inside {OP_CMP_SKIP, OP_SKIP_RBIT_CLR, OP_SKIP_RBIT_SET,
                           OP_SKIP_IOBIT_CLR, OP_SKIP_IOBIT_SET};
  wire is_brf = op inside {OP_BR_FLAG_SET, OP_BR_FLAG_CLR};
  wire use_c  = op inside {OP_ADD_CARRY, OP_SUB_BORROW, OP_SUB_IMM_BORROW, OP_CMP_BORROW};
  wire chain_z = use_c & ~is_add;
  wire writes = op inside {OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_SUB_IMM,
                           OP_SUB_IMM_BORROW, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
                           OP_XOR, OP_MOVE, OP_LOAD_CONST, OP_IO_READ, OP_LOAD_Z,
                           OP_STORE_Z};

  // ----------------------------------------------------------------
  // Operands and ALU
  // ----------------------------------------------------------------
  wire [4:0]  dst    = imm_op ? d_hi : d_full;
  wire [7:0]  a      = rf_q[dst];
  wire [7:0]  b_reg  = rf_q[r_sel];
  wire [7:0]  b      = imm_op ? k_imm : b_reg;
  wire [4:0]  z_addr = rf_q[`Z_PTR_LO][4:0];
  wire        cin    = use_c & flag_q[`FLAG_C];
  wire [8:0]  sum    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  wire [4:0]  sum_lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  wire [8:0]  dif    = {1'b0, a} - {1'b0, b} - {8'h00, cin};
  wire [4:0]  dif_lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
  logic [7:0] res;

  always_comb begin
    res = a;
    if (is_add)
      res = sum[7:0];
    else if (is_sub)
      res = dif[7:0];
    else if (is_and)
      res = a & b;
    else if (is_or)
      res = a | b;
    else if (op == OP_XOR)
      res = a ^ b;
    else if (op == OP_MOVE)
      res = b_reg;
    else if (op == OP_LOAD_CONST)
      res = k_imm;
    else if (op == OP_IO_READ)
      res = io_rdata;
    else if (op == OP_LOAD_Z)
      res = rf_q[z_addr];
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Borrow forms chain Z so multi-byte compares report zero only when all bytes match
  wire zero_r = (res == 8'h00);
  wire z_new  = chain_z ? (zero_r & flag_q[`FLAG_Z]) : zero_r;
  wire v_add  = (a[7] == b[7]) & (res[7] != a[7]);
  wire v_sub  = (a[7] != b[7]) & (res[7] != a[7]);

  always_comb begin
    flag_d = flag_q;
    if (is_add) begin
      flag_d[`FLAG_C] = sum[8];
      flag_d[`FLAG_H] = sum_lo[4];
      flag_d[`FLAG_V] = v_add;
    end
    if (is_sub) begin
      flag_d[`FLAG_C] = dif[8];
      flag_d[`FLAG_H] = dif_lo[4];
      flag_d[`FLAG_V] = v_sub;
    end
    if (is_log)
      flag_d[`FLAG_V] = 1'b0;
    if (is_add | is_sub | is_log) begin
      flag_d[`FLAG_N] = res[7];
      flag_d[`FLAG_Z] = z_new;
      flag_d[`FLAG_S] = res[7] ^ flag_d[`FLAG_V];
    end
    if (op == OP_INT_EXIT)
      flag_d[`FLAG_I] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Skip and branch conditions
  // ----------------------------------------------------------------
  // Alias branches are the flag branch with a fixed bit: C, V, H, T, I or S
  wire  flag_bit = flag_q[bit_sel];
  wire  iob      = io_rdata[bit_sel];
  logic take;

  always_comb begin
    take = 1'b0;
    if (op == OP_CMP_SKIP)
      take = (a == b_reg);
    else if (op == OP_SKIP_RBIT_CLR)
      take = ~a[bit_sel];
    else if (op == OP_SKIP_RBIT_SET)
      take = a[bit_sel];
    else if (op == OP_SKIP_IOBIT_CLR)
      take = ~iob;
    else if (op == OP_SKIP_IOBIT_SET)
      take = iob;
    else if (op == OP_BR_FLAG_SET)
      take = flag_bit;
    else if (op == OP_BR_FLAG_CLR)
      take = ~flag_bit;
  end

  // ----------------------------------------------------------------
  // Program counter sequencing
  // ----------------------------------------------------------------
  wire [`PC_W-1:0] pc_inc  = pc_q + `PC_W'(1);
  wire [`PC_W-1:0] br_tgt  = pc_inc + {{(`PC_W-7){br_off[6]}}, br_off};
  wire [`PC_W-1:0] jmp_tgt = pc_inc + ins[`PC_W-1:0];

  // Extra cycles are counted down with fetch frozen; a skip discards the next word
  always_comb begin
    pc_d   = pc_q;
    wait_d = wait_q;
    skip_d = skip_q;
    push   = 1'b0;
    pop    = 1'b0;
    if (run) begin
      if (wait_q != 2'h0) begin
        wait_d = wait_q - 2'h1;
      end else if (skip_q) begin
        pc_d   = pc_inc;
        skip_d = 1'b0;
      end else begin
        pc_d = pc_inc;
        if (op == OP_REL_JUMP) begin
          pc_d   = jmp_tgt;
          wait_d = 2'(`CYC_JUMP - 1);
        end else if (op == OP_REL_CALL) begin
          push   = 1'b1;
          pc_d   = jmp_tgt;
          wait_d = 2'(`CYC_CALL - 1);
        end else if (op inside {OP_POP_PC, OP_INT_EXIT}) begin
          pop    = 1'b1;
          pc_d   = stk_q[0];
          wait_d = 2'(`CYC_RETURN - 1);
        end else if (op inside {OP_LOAD_Z, OP_STORE_Z}) begin
          wait_d = 2'(`CYC_MEM - 1);
        end else if (is_brf & take) begin
          pc_d   = br_tgt;
          wait_d = 2'(`CYC_BRANCH - 1);
        end else if (is_skp & take) begin
          skip_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q   <= '0;
      wait_q <= 2'h0;
      skip_q <= 1'b0;
      flag_q <= `FLAG_RESET;
    end else begin
      pc_q   <= pc_d;
      wait_q <= wait_d;
      skip_q <= skip_d;
      if (exec)
        flag_q <= flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // Shift stack: an overflowing push silently drops the oldest entry
  for (genvar i = 0; i < `STACK_DEPTH; i++) begin : g_stk
    wire [`PC_W-1:0] above = (i == 0) ? pc_inc : stk_q[(i + `STACK_DEPTH - 1) % `STACK_DEPTH];
    wire [`PC_W-1:0] below = (i == `STACK_DEPTH - 1) ? stk_q[i] : stk_q[(i + 1) % `STACK_DEPTH];
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
        stk_q[i] <= '0;
      else if (push)
        stk_q[i] <= above;
      else if (pop)
        stk_q[i] <= below;
    end
  end

  // ----------------------------------------------------------------
  // Register file and debug port
  // ----------------------------------------------------------------
  wire       rf_we   = exec & writes;
  wire [4:0] rf_wa   = (op == OP_STORE_Z) ? z_addr : dst;
  wire [7:0] rf_wd   = (op == OP_STORE_Z) ? a : res;
  // Debug writes to the register file are honoured only while halted
  wire       dbg_rfw = dbg_req.wr & ~run & ~dbg_req.addr[5];
  wire       dbg_ctw = dbg_req.wr & (dbg_req.addr == `DBG_CTRL);
  wire [7:0] dbg_mux = ~dbg_req.addr[5]          ? rf_q[dbg_req.addr[4:0]] :
                       (dbg_req.addr == `DBG_CTRL)  ? ctrl_q :
                       (dbg_req.addr == `DBG_FLAGS) ? flag_q :
                       (dbg_req.addr == `DBG_PC_LO) ? pc_q[7:0] :
                       (dbg_req.addr == `DBG_PC_HI) ? 8'(pc_q[`PC_W-1:8]) : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++)
        rf_q[i] <= 8'h00;
    end else if (rf_we) begin
      rf_q[rf_wa] <= rf_wd;
    end else if (dbg_rfw) begin
      rf_q[dbg_req.addr[4:0]] <= dbg_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q      <= `CTRL_RESET;
      dbg_rdata_q <= 8'h00;
    end else begin
      if (dbg_ctw)
        ctrl_q <= dbg_req.wdata;
      dbg_rdata_q <= dbg_req.rd ? dbg_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire io_bit_op = op inside {OP_SKIP_IOBIT_CLR, OP_SKIP_IOBIT_SET};
  assign io_req.addr  = io_bit_op ? {1'b0, iob_addr} : io_addr;
  assign io_req.wdata = a;
  assign io_req.wr    = exec & (op == OP_IO_WRITE);
  assign io_req.rd    = exec & ((op == OP_IO_READ) | io_bit_op);
  assign pm_addr      = pc_q;
  assign issue        = exec;
  assign flags        = flag_q;
  assign dbg_rdata    = dbg_rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_hold3;
    !issue [*3];
  endsequence

  sequence s_skip_done;
    skip_q ##1 (!skip_q && pc_q == $past(pc_q, 2) + `PC_W'(2));
  endsequence

  a_add_sum: assert property (exec && op == OP_ADD |=>
    rf_q[$past(dst)] == 8'($past(a) + $past(b))) else $error("add result wrong");
  a_sub_borrow: assert property (exec && op == OP_SUB |=>
    flag_q[`FLAG_C] == ($past(a) < $past(b_reg))) else $error("subtract borrow wrong");
  a_subtract_immediate_value: assert property (exec && op == OP_SUB_IMM |=>
    rf_q[$past(dst)] == 8'($past(a) - $past(k_imm))) else $error("immediate subtract wrong");
  a_and_keeps_c: assert property (exec && is_and |=>
    $stable(flag_q[`FLAG_C]) && $stable(flag_q[`FLAG_H]) && !flag_q[`FLAG_V])
    else $error("logic op touched carry");
  a_or_zero: assert property (exec && is_or |=>
    flag_q[`FLAG_Z] == ($past(a | b) == 8'h00)) else $error("or zero flag wrong");
  a_cmp_no_write: assert property (exec && is_cmp |-> !rf_we)
    else $error("compare wrote a register");
  a_skip_equal: assert property (exec && op == OP_CMP_SKIP && a == b_reg |=>
    s_skip_done) else $error("equal skip timing wrong");
  a_branch_tgt: assert property (exec && is_brf && take |=>
    !issue && pc_q == $past(br_tgt)) else $error("branch target wrong");
  a_signed_less: assert property (exec && is_brf && bit_sel == 3'(`FLAG_S) |->
    take == ((flag_q[`FLAG_N] ^ flag_q[`FLAG_V]) ^ (op == OP_BR_FLAG_CLR)))
    else $error("signed branch condition wrong");
  a_pop_time: assert property (exec && op == OP_POP_PC && run |=>
    s_hold3 ##1 (issue || !run)) else $error("return not four cycles");
  a_call_push: assert property (exec && op == OP_REL_CALL |=>
    stk_q[0] == $past(pc_inc) && pc_q == $past(jmp_tgt)) else $error("call push wrong");
  a_move_flags: assert property (exec && op inside {OP_MOVE, OP_LOAD_CONST, OP_IO_READ,
    OP_IO_WRITE, OP_LOAD_Z, OP_STORE_Z} |=> $stable(flag_q)) else $error("transfer hit flags");

endmodule

//--- program_io_model.sv
// Program memory and I/O register space facing the execute core
`timescale 1ns/100ps
`include "core_consts.svh"
module program_io_model (
  input  wire logic             clk,
  input  wire logic [`PC_W-1:0] pm_addr,
  output logic [15:0]           pm_data,
  input  wire core_pkg::io_req_t io_req,
  output logic [7:0]            io_rdata
);
  import core_pkg::*;
  logic [15:0] rom [512];
  logic [7:0]  io_q [64];

  initial begin
    for (int i = 0; i < 64; i++) io_q[i] = 8'h00;
  end

  assign pm_data = rom[pm_addr];
  // Outside a read the data is inverted, so a core sampling late sees garbage
  assign io_rdata = io_req.rd ? io_q[io_req.addr] : ~io_q[io_req.addr];

  // Plain always: the initial block above also writes this array
  always @(posedge clk) begin
    if (io_req.wr) io_q[io_req.addr] <= io_req.wdata;
  end
endmodule

//--- test_tiny_core_instruction_execute.sv
// Self-checking bench: preload registers, run a short program, read results back
`timescale 1ns/100ps
`include "core_consts.svh"
module test_tiny_core_instruction_execute;
  import core_pkg::*;
  logic             clk;
  logic             reset_n;
  logic [`PC_W-1:0] pm_addr;
  logic [15:0]      pm_data;
  io_req_t          io_req;
  logic [7:0]       io_rdata;
  dbg_req_t         dbg_req;
  logic [7:0]       dbg_rdata;
  logic             issue;
  logic [7:0]       flags;
  logic [7:0]       exp_q [$];
  logic [31:0]      seed;
  logic [7:0]       a, b, k, d, cyc, fl;
  logic             pend = 1'b0;
  int               failures, n_tests;

  tiny_core_instruction_execute u_dut (.clk(clk), .reset_n(reset_n), .pm_addr(pm_addr),
    .pm_data(pm_data), .io_req(io_req), .io_rdata(io_rdata), .dbg_req(dbg_req),
    .dbg_rdata(dbg_rdata), .issue(issue), .flags(flags));
  program_io_model u_mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .io_req(io_req), .io_rdata(io_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] rr(input logic [5:0] op, input logic [4:0] rd,
                                     input logic [4:0] rs);
    return {op, rs[4], rd, rs[3:0]};
  endfunction
  function automatic logic [15:0] ki(input logic [3:0] op, input logic [4:0] rd,
                                     input logic [7:0] kv);
    return {op, kv[7:4], rd[3:0], kv[3:0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic dwr(input logic [5:0] ad, input logic [7:0] wd);
    @(posedge clk) dbg_req <= '{ad, wd, 1'b1, 1'b0};
    @(posedge clk) dbg_req <= '0;
  endtask
  task automatic drd(input logic [5:0] ad, input logic [7:0] ex);
    exp_q.push_back(ex);
    @(posedge clk) dbg_req <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge clk) dbg_req <= '0;
  endtask
  task automatic results;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Read data stands one cycle after the strobe; sampled mid-cycle to avoid races
  always @(negedge clk) begin
    if (pend) check(dbg_rdata, exp_q.pop_front());
    pend = dbg_req.rd;
  end

  // Whole run is about 100 cycles; this limit is far beyond it
  initial begin
    #20000;
    failures++;
    results;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    dbg_req = '0;
    seed = lfsr(32'h3893D233);
    a = seed[7:0];
    b = seed[15:8];
    k = seed[23:16];
    for (int i = 0; i < 512; i++) u_mem.rom[i] = 16'h0000;
    u_mem.rom[0] = rr(6'h03, 5'd18, 5'd17);
    u_mem.rom[1] = rr(6'h06, 5'd19, 5'd17);
    u_mem.rom[2] = rr(6'h08, 5'd20, 5'd17);
    u_mem.rom[3] = rr(6'h0A, 5'd21, 5'd17);
    u_mem.rom[4] = ki(4'h5, 5'd22, k);
    u_mem.rom[5] = ki(4'h7, 5'd23, 8'hFF - k);
    u_mem.rom[6] = 16'hB905;
    u_mem.rom[7] = 16'hB1B5;
    u_mem.rom[8] = rr(6'h05, 5'd16, 5'd17);
    u_mem.rom[9] = rr(6'h04, 5'd16, 5'd16);
    u_mem.rom[10] = ki(4'hE, 5'd24, 8'h11);
    u_mem.rom[11] = 16'hF008;
    u_mem.rom[12] = ki(4'hE, 5'd25, 8'h55);
    u_mem.rom[13] = 16'hD002;
    u_mem.rom[14] = ki(4'hE, 5'd26, 8'h77);
    u_mem.rom[15] = 16'hCFFF;
    // Subroutine: store and load through Z, then a register-bit and an I/O-bit skip
    u_mem.rom[16] = 16'h8310;
    u_mem.rom[17] = 16'h81D0;
    u_mem.rom[18] = 16'hFF07;
    u_mem.rom[19] = rr(6'h0B, 5'd31, 5'd17);
    u_mem.rom[20] = 16'h9928;
    u_mem.rom[21] = ki(4'hE, 5'd30, 8'h44);
    u_mem.rom[22] = 16'h9508;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 16; i < 24; i++) dwr(6'(i), (i == 17) ? b : a);
    dwr(`DBG_CTRL, 8'h01);
    for (cyc = 0; cyc < 60; cyc++) begin
      @(negedge clk);
      if (issue === 1'b1 && pm_addr === 9'd15) break;
    end
    check(cyc, 8'd29);
    dwr(6'd28, 8'hAA);
    dwr(`DBG_CTRL, 8'h00);
    d = a - b;
    fl = {2'b00, (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]),
          d[7] ^ ((a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7])),
          (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]), d[7], d == 8'h00, a < b};
    drd(6'd18, 8'(a + b));
    drd(6'd19, d);
    drd(6'd20, a & b);
    drd(6'd21, a | b);
    drd(6'd22, 8'(a - k));
    drd(6'd23, a & (8'hFF - k));
    drd(6'd27, a);
    drd(6'd24, 8'h00);
    drd(6'd25, fl[0] ? 8'h00 : 8'h55);
    drd(6'd26, 8'h77);
    drd(6'd28, 8'h00);
    drd(6'd0, b);
    drd(6'd29, b);
    drd(6'd31, a[7] ? 8'h00 : b);
    drd(6'd30, a[0] ? 8'h44 : 8'h00);
    drd(6'd16, a);
    drd(`DBG_FLAGS, fl);
    drd(6'h30, 8'h00);
    repeat (4) @(posedge clk);
    results;
  end
endmodule
